// >>> hdl/pp_cfg.svh
// constants for the panel poller: address range, loss limit, timing, reset values
// assumes the includer also imports pp_pkg for the matching types
`ifndef PP_CFG_SVH
`define PP_CFG_SVH

`define PP_CLK_MHZ      250
`define PP_ADDR_W       7
`define PP_ADDR_LAST    7'h63
`define PP_LOST_POLLS   4'ha
`define PP_SLOT_US      2500
`define PP_SLOT_CYC     (`PP_SLOT_US * `PP_CLK_MHZ)
`define PP_DEB_US       10000
`define PP_DEB_CYC      (`PP_DEB_US * `PP_CLK_MHZ)
`define PP_TMR_W        24
`define PP_PRESET_G1_CL 3'h1
`define PP_PRESET_G1_OP 3'h2
`define PP_PRESET_G2_CL 3'h3
`define PP_PRESET_G2_OP 3'h4
`define PP_ENTRY_RST    5'h00

`endif

// >>> hdl/pp_pkg.sv
// types shared by the panel poller and its address table
// assumes nothing outside itself
package pp_pkg;

  typedef enum logic [1:0] {PP_REQ_POLL, PP_REQ_RECALL, PP_REQ_STATUS} pp_req_kind_e;

  typedef enum logic [2:0] {
    MSG_FOUND, MSG_SELECTED_DEVICE, MSG_MODULE_ADDED, MSG_GONE, MSG_LINK_ERROR, MSG_STATUS
  } pp_msg_kind_e;

  typedef struct packed {
    pp_req_kind_e kind;
    logic [6:0]   addr;
    logic [2:0]   preset;
  } pp_req_s;

  typedef struct packed {
    logic       done;
    logic [7:0] status;
  } pp_rsp_s;

  typedef struct packed {
    pp_msg_kind_e kind;
    logic [6:0]   addr;
    logic [6:0]   count;
    logic [7:0]   status;
  } pp_msg_s;

  typedef struct packed {
    logic       active;
    logic [3:0] misses;
  } pp_entry_s;

endpackage

// >>> hdl/pp_poller.sv
// panel poller: sweeps module addresses, tracks arrivals and losses,
// recalls presets on gpi edges and reports module status to the display
// assumes gpi inputs and link answers are synchronous to mclk; one answer per request
//
// Notes on behaviour
// - gpi one closing recalls preset 1 to the selected module.
// - gpi one opening recalls preset 2 to the selected module.
// - gpi two closing recalls preset 3, opening recalls preset 4.
// - power-on sweep polls every address from 0 to 0x63, records responders, reports count found.
// - lowest responding address becomes the first selected module.
// - polling continues forever; arrivals and losses raise display messages.
// - newly responding address gives module-added message and is marked active.
// - ten consecutive missed polls mark a module lost and report its address.
// - unexecuted command is followed by status query; status shown with link error.
// - fault status from the selected module is shown above its address.
`timescale 1ns/1ns
`include "pp_cfg.svh"
module pp_poller
  import pp_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `PP_SLOT_CYC,
  parameter int unsigned DEB_CYC  = `PP_DEB_CYC
)(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // gpi contacts, high while closed
  input  wire logic [1:0] gpi_closed,
  // requests toward the module network
  output logic            req_valid,
  output pp_req_s         req,
  // answers from the addressed module
  input  wire logic       rsp_valid,
  input  pp_rsp_s         rsp,
  // display
  output logic            msg_valid,
  output pp_msg_s         msg,
  output logic [6:0]      module_id_window,
  output logic            sel_valid
);

  typedef enum logic [2:0] {
    ST_POLL_REQ, ST_POLL_WAIT, ST_FOUND, ST_SEL, ST_CMD_WAIT, ST_STAT_WAIT
  } pp_state_e;

  localparam logic [`PP_TMR_W-1:0] SLOT_LIM = `PP_TMR_W'(SLOT_CYC - 1);
  localparam logic [`PP_TMR_W-1:0] DEB_LIM  = `PP_TMR_W'(DEB_CYC - 1);

  // preset for the lowest pending gpi event
  function automatic logic [2:0] preset_of(input logic [3:0] low);
    unique case (1'b1)
      low[0]:  preset_of = `PP_PRESET_G1_CL;
      low[1]:  preset_of = `PP_PRESET_G1_OP;
      low[2]:  preset_of = `PP_PRESET_G2_CL;
      default: preset_of = `PP_PRESET_G2_OP;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // gpi debounce and pending recalls
  logic [1:0]           deb_q, deb_d;
  logic [`PP_TMR_W-1:0] dcnt_q [2];
  logic [`PP_TMR_W-1:0] dcnt_d [2];
  logic [3:0]           pend_q, pend_d, pend_set, pend_clr, pend_low;

  // a level must hold a full window before it counts, so bounce gives one edge
  always_comb begin
    deb_d    = deb_q;
    pend_set = 4'h0;
    for (int i = 0; i < 2; i++) begin
      dcnt_d[i] = '0;
      if (gpi_closed[i] != deb_q[i]) begin
        if (dcnt_q[i] == DEB_LIM) begin
          deb_d[i] = gpi_closed[i];
          pend_set[2*i]   = gpi_closed[i];
          pend_set[2*i+1] = !gpi_closed[i];
        end else begin
          dcnt_d[i] = dcnt_q[i] + `PP_TMR_W'(1);
        end
      end
    end
    pend_d = (pend_q & ~pend_clr) | pend_set;               // a new edge wins over a clear
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      deb_q     <= 2'h0;
      dcnt_q[0] <= '0;
      dcnt_q[1] <= '0;
      pend_q    <= 4'h0;
    end else begin
      deb_q     <= deb_d;
      dcnt_q[0] <= dcnt_d[0];
      dcnt_q[1] <= dcnt_d[1];
      pend_q    <= pend_d;
    end
  end

  assign pend_low = pend_q & (~pend_q + 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // poll sequencer
  pp_state_e            st_q, st_d;
  logic [6:0]           addr_q, addr_d, found_q, found_d, sel_q, sel_d;
  logic                 init_q, init_d, selv_q, selv_d;
  logic [`PP_TMR_W-1:0] tmr_q, tmr_d;
  logic                 req_v_q, req_v_d, msg_v_q, msg_v_d;
  pp_req_s              req_q, req_d;
  pp_msg_s              msg_q, msg_d;
  logic                 tbl_rd, tbl_wr, timeout;
  pp_entry_s            ent, wdat;

  pp_table u_table (
    .mclk    (mclk),
    .nrst    (nrst),
    .rd_en   (tbl_rd),
    .rd_addr (addr_q),
    .rd_data (ent),
    .wr_en   (tbl_wr),
    .wr_addr (addr_q),
    .wr_data (wdat)
  );

  assign timeout = (tmr_q == SLOT_LIM);

  always_comb begin
    st_d = st_q;  addr_d = addr_q;  found_d = found_q;  sel_d = sel_q;
    init_d = init_q;  selv_d = selv_q;  tmr_d = tmr_q + `PP_TMR_W'(1);
    req_v_d = 1'b0;  req_d = req_q;  msg_v_d = 1'b0;  msg_d = msg_q;
    pend_clr = 4'h0;  tbl_rd = 1'b0;  tbl_wr = 1'b0;  wdat = ent;
    unique case (st_q)
      ST_POLL_REQ: begin
        tmr_d   = '0;
        req_v_d = 1'b1;
        if (!init_q && selv_q && |pend_q) begin
          // recalls go to the selected module between polls
          req_d    = '{kind: PP_REQ_RECALL, addr: sel_q, preset: preset_of(pend_low)};
          pend_clr = pend_low;
          st_d     = ST_CMD_WAIT;
        end else begin
          req_d  = '{kind: PP_REQ_POLL, addr: addr_q, preset: 3'h0};
          tbl_rd = 1'b1;
          st_d   = ST_POLL_WAIT;
        end
      end
      ST_POLL_WAIT: begin
        if (rsp_valid || timeout) begin
          tbl_wr = 1'b1;
          st_d   = ST_POLL_REQ;
          if (rsp_valid) begin
            wdat = '{active: 1'b1, misses: 4'h0};
            msg_d.addr   = addr_q;
            msg_d.status = rsp.status;
            if (init_q) begin
              found_d = found_q + 7'h1;
              if (found_q == 7'h0) begin
                sel_d = addr_q;                              // ascending sweep
              end
            end else if (!ent.active) begin
              msg_v_d    = 1'b1;
              msg_d.kind = MSG_MODULE_ADDED;
            end else if (selv_q && addr_q == sel_q && rsp.status != 8'h00) begin
              msg_v_d    = 1'b1;
              msg_d.kind = MSG_STATUS;
            end
          end else if (init_q) begin
            wdat = `PP_ENTRY_RST;
          end else if (ent.active) begin
            wdat.misses = ent.misses + 4'h1;
            if (wdat.misses == `PP_LOST_POLLS) begin
              wdat = `PP_ENTRY_RST;
              msg_v_d = 1'b1;
              msg_d   = '{kind: MSG_GONE, addr: addr_q, count: found_q, status: 8'h00};
            end
          end
          // sweep wraps and keeps running after power-on
          if (addr_q == `PP_ADDR_LAST) begin
            addr_d = 7'h0;
            if (init_q) begin
              st_d = ST_FOUND;
            end
          end else begin
            addr_d = addr_q + 7'h1;
          end
        end
      end
      ST_FOUND: begin
        msg_v_d = 1'b1;
        msg_d   = '{kind: MSG_FOUND, addr: 7'h0, count: found_q, status: 8'h00};
        st_d    = ST_SEL;
      end
      ST_SEL: begin
        init_d = 1'b0;
        st_d   = ST_POLL_REQ;
        if (found_q != 7'h0) begin
          selv_d  = 1'b1;
          msg_v_d = 1'b1;
          msg_d   = '{kind: MSG_SELECTED_DEVICE, addr: sel_q, count: found_q, status: 8'h00};
        end
      end
      ST_CMD_WAIT: begin
        if (rsp_valid && rsp.done) begin
          st_d = ST_POLL_REQ;
        end else if (rsp_valid || timeout) begin
          // not executed, or silent: ask the module why
          req_v_d = 1'b1;
          req_d   = '{kind: PP_REQ_STATUS, addr: sel_q, preset: 3'h0};
          tmr_d   = '0;
          st_d    = ST_STAT_WAIT;
        end
      end
      ST_STAT_WAIT: begin
        if (rsp_valid || timeout) begin
          msg_v_d = 1'b1;
          msg_d   = '{kind: MSG_LINK_ERROR, addr: sel_q, count: found_q,
                      status: rsp_valid ? rsp.status : 8'h00};
          st_d    = ST_POLL_REQ;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_POLL_REQ;  addr_q <= 7'h0;  found_q <= 7'h0;  sel_q <= 7'h0;
      init_q <= 1'b1;  selv_q <= 1'b0;  tmr_q <= '0;
      req_v_q <= 1'b0;  req_q <= '0;  msg_v_q <= 1'b0;  msg_q <= '0;
    end else begin
      st_q <= st_d;  addr_q <= addr_d;  found_q <= found_d;  sel_q <= sel_d;
      init_q <= init_d;  selv_q <= selv_d;  tmr_q <= tmr_d;
      req_v_q <= req_v_d;  req_q <= req_d;  msg_v_q <= msg_v_d;  msg_q <= msg_d;
    end
  end

  assign req_valid        = req_v_q;
  assign req              = req_q;
  assign msg_valid        = msg_v_q;
  assign msg              = msg_q;
  assign module_id_window = sel_q;
  assign sel_valid        = selv_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // the pending bit lands with the debounced level and may be served one cycle later
  chk_close_one_pend: assert property ($rose(deb_q[0]) |-> pend_q[0])
    else $error("gpi one closing did not queue a recall");
  chk_open_one_pend: assert property ($fell(deb_q[0]) |-> pend_q[1])
    else $error("gpi one opening did not queue a recall");
  chk_close_two_pend: assert property ($rose(deb_q[1]) |-> pend_q[2])
    else $error("gpi two closing did not queue a recall");
  chk_recall_target: assert property (req_v_q && req_q.kind == PP_REQ_RECALL
      |-> selv_q && req_q.addr == sel_q && req_q.preset == preset_of($past(pend_low)))
    else $error("recall sent to wrong module or preset");
  chk_found_then_sel: assert property (msg_v_q && msg_q.kind == MSG_FOUND && msg_q.count != 7'h0
      |=> msg_v_q && msg_q.kind == MSG_SELECTED_DEVICE && msg_q.addr == sel_q)
    else $error("count report not followed by selected device");
  chk_added_marks: assert property (msg_v_q && msg_q.kind == MSG_MODULE_ADDED
      |-> $past(tbl_wr) && $past(wdat.active) && !$past(init_q))
    else $error("module added without table update");
  chk_gone_after_ten: assert property (msg_v_q && msg_q.kind == MSG_GONE
      |-> $past(ent.misses) == 4'h9 && !$past(rsp_valid))
    else $error("module lost at wrong miss count");
  chk_status_query: assert property (st_q == ST_CMD_WAIT && rsp_valid && !rsp.done
      |=> req_v_q && req_q.kind == PP_REQ_STATUS ##1 st_q == ST_STAT_WAIT)
    else $error("no status query after unexecuted command");
  chk_link_err_show: assert property (st_q == ST_STAT_WAIT && rsp_valid
      |=> msg_v_q && msg_q.kind == MSG_LINK_ERROR && msg_q.status == $past(rsp.status))
    else $error("returned status not shown with link error");
  chk_deb_hold: assert property ($changed(deb_q[0]) |-> $past(dcnt_q[0]) == DEB_LIM)
    else $error("gpi accepted before debounce window");
  chk_poll_keeps: assert property (!init_q && st_q == ST_POLL_REQ && !(selv_q && |pend_q)
      |=> req_v_q && req_q.kind == PP_REQ_POLL)
    else $error("polling stopped after power-on");

  cov_recall: cover property (req_v_q && req_q.kind == PP_REQ_RECALL);
  cov_added: cover property (msg_v_q && msg_q.kind == MSG_MODULE_ADDED);
  cov_gone: cover property (msg_v_q && msg_q.kind == MSG_GONE);
  cov_link_err: cover property (msg_v_q && msg_q.kind == MSG_LINK_ERROR);

endmodule // pp_poller

// >>> hdl/pp_table.sv
// per-address table: active flag and consecutive miss count
// assumes one read or write per cycle; contents are undefined until the first sweep
`timescale 1ns/1ns
`include "pp_cfg.svh"
module pp_table
  import pp_pkg::*;
(
  // clock and reset
  input  wire logic      mclk,
  input  wire logic      nrst,
  // read port, data one cycle later
  input  wire logic      rd_en,
  input  wire logic [6:0] rd_addr,
  output pp_entry_s      rd_data,
  // write port
  input  wire logic      wr_en,
  input  wire logic [6:0] wr_addr,
  input  pp_entry_s      wr_data
);

  pp_entry_s mem [128];
  pp_entry_s rd_d;
  pp_entry_s rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // storage carries no reset; the power-on sweep writes every used entry
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data held in a register until the next read
  always_comb begin
    rd_d = rd_q;
    if (rd_en) begin
      rd_d = mem[rd_addr];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= `PP_ENTRY_RST;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;

endmodule // pp_table

// >>> testbench/pp_net_model.sv
// network model: addressed mixer modules sharing one request and answer link
// assumes the poller keeps one request outstanding; controls come from the bench
`timescale 1ns/1ns
module pp_net_model
  import pp_pkg::*;
#(
  parameter int unsigned SLOW_DLY = 12
)(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // requests from the panel
  input  wire logic         req_valid,
  input  pp_req_s           req,
  // answers to the panel
  output logic              rsp_valid,
  output pp_rsp_s           rsp,
  // scenario controls
  input  wire logic [127:0] present,
  input  wire logic         slow,
  input  wire logic         nak_recall,
  input  wire logic [7:0]   poll_stat,
  input  wire logic [7:0]   stat_val
);
  logic [4:0] wait_q;
  pp_rsp_s    ans_q;
  pp_rsp_s    ans;

  // answer content by command; an unknown code earns a protocol error
  always_comb begin
    case (req.kind)
      PP_REQ_POLL:   ans = {1'b1, poll_stat};
      PP_REQ_RECALL: ans = {~nak_recall, 8'h00};
      PP_REQ_STATUS: ans = {1'b1, stat_val};
      default:       ans = {1'b0, 8'hee};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // only a present module whose address matches answers, promptly or late
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
      wait_q    <= '0;
      ans_q     <= '0;
    end else begin
      rsp_valid <= 1'b0;
      rsp       <= ~rsp; // released line: inverted every cycle, so the stale answer returns on alternate cycles
      if (wait_q != 5'h00) begin
        wait_q <= wait_q - 5'h01;
      end
      if (wait_q == 5'h01) begin
        rsp_valid <= 1'b1;
        rsp       <= ans_q;
      end
      if (req_valid && present[req.addr]) begin
        if (slow) begin
          wait_q <= SLOW_DLY[4:0];
          ans_q  <= ans;
        end else begin
          rsp_valid <= 1'b1;
          rsp       <= ans;
        end
      end
    end
  end
endmodule // pp_net_model

// >>> testbench/test_pp_poller.sv
// bench for the panel poller: power-on sweep, arrival, loss, gpi recalls, status
// assumes pp_net_model on the link and shortened slot and debounce counts
`timescale 1ns/1ns
module test_pp_poller
  import pp_pkg::*;
;
  localparam int unsigned SLOT = 20;
  localparam int unsigned DEB  = 4;

  logic         mclk = 1'b0;
  logic         nrst;
  logic [1:0]   gpi_closed;
  logic         req_valid;
  pp_req_s      req;
  logic         rsp_valid;
  pp_rsp_s      rsp;
  logic         msg_valid;
  pp_msg_s      msg;
  logic [6:0]   module_id_window;
  logic         sel_valid;
  logic [127:0] present;
  logic         slow;
  logic         nak_recall;
  logic [7:0]   poll_stat;
  logic [7:0]   stat_val;
  logic [31:0]  seed = 32'hb197;
  int           err_count = 0;
  int           samples_checked = 0;
  int           cyc = 0;
  int           t0;
  int           per;
  int           k;
  logic         lv;
  logic [7:0]   s;
  pp_msg_s      m;
  pp_msg_s      exp_msg[$];
  logic [2:0]   exp_rec[$];

  pp_poller #(.SLOT_CYC(SLOT), .DEB_CYC(DEB)) i_pp_poller (
    .mclk(mclk), .nrst(nrst), .gpi_closed(gpi_closed), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .msg_valid(msg_valid), .msg(msg),
    .module_id_window(module_id_window), .sel_valid(sel_valid));
  pp_net_model i_pp_net_model (
    .mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
    .rsp(rsp), .present(present), .slow(slow), .nak_recall(nak_recall),
    .poll_stat(poll_stat), .stat_val(stat_val));

  // 250 MHz clock and a free cycle count for timing the loss
  always #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic push_msg(input pp_msg_kind_e kd, input logic [6:0] a, input logic [7:0] st);
    exp_msg.push_back('{kind: kd, addr: a, count: 7'h03, status: st});
  endtask

  // bounded wait until every noted result has been seen; random answer pace meanwhile
  task automatic drain(input int bound);
    int n;
    n = 0;
    while (exp_msg.size() + exp_rec.size() != 0 && n < bound) begin
      @(posedge mclk);
      slow <= 1'($random(seed));
      n++;
    end
    if (exp_msg.size() + exp_rec.size() != 0) begin
      check("pending results", 32'h0, 32'(exp_msg.size() + exp_rec.size()));
      conclude();
    end
  endtask

  task automatic wait_poll(input logic [6:0] a);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(req_valid === 1'b1 && req.kind === PP_REQ_POLL && req.addr === a) && n < 5000);
    if (!(req_valid === 1'b1 && req.kind === PP_REQ_POLL && req.addr === a)) begin
      check("poll seen", 32'h1, 32'h0);
      conclude();
    end
  endtask

  // watcher: each message or recall takes the oldest note and compares
  always @(posedge mclk) begin
    if (nrst && msg_valid) begin
      if (exp_msg.size() == 0) check("message kind", 32'hff, 32'(msg.kind));
      else begin
        m = exp_msg.pop_front();
        check("message kind", 32'(m.kind), 32'(msg.kind));
        if (m.kind == MSG_FOUND) check("module count", 32'(m.count), 32'(msg.count));
        else check("message address", 32'(m.addr), 32'(msg.addr));
        if (m.kind inside {MSG_LINK_ERROR, MSG_STATUS})
          check("message status", 32'(m.status), 32'(msg.status));
      end
    end
    if (nrst && req_valid && req.kind == PP_REQ_RECALL) begin
      if (exp_rec.size() == 0) check("recall preset", 32'hff, 32'(req.preset));
      else begin
        check("recall preset", 32'(exp_rec.pop_front()), 32'(req.preset));
        check("recall address", 32'h05, 32'(req.addr));
      end
    end
    // the follow-up query must go to the selected module
    if (nrst && req_valid && req.kind == PP_REQ_STATUS)
      check("status query address", 32'h05, 32'(req.addr));
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst       = 1'b0;
    gpi_closed = 2'b00;
    present    = 128'h400_0002_0020; // modules at 5, 17 and 42
    slow       = 1'b0;
    nak_recall = 1'b0;
    poll_stat  = 8'h00;
    stat_val   = 8'h00;
    repeat (16) @(posedge mclk);
    check("select in reset", 32'h0, 32'(sel_valid));
    nrst <= 1'b1;
    push_msg(MSG_FOUND, 7'h00, 8'h00);
    push_msg(MSG_SELECTED_DEVICE, 7'h05, 8'h00);
    drain(8000);
    check("selected flag", 32'h1, 32'(sel_valid));
    check("selected address", 32'h05, 32'(module_id_window));
    // a module plugged in after power-on is announced
    present[60] <= 1'b1;
    push_msg(MSG_MODULE_ADDED, 7'h3c, 8'h00);
    drain(8000);
    // each contact edge: a glitch shorter than the debounce first, then a real change
    for (k = 0; k < 4; k++) begin
      lv = ~k[0];
      gpi_closed[k / 2] <= lv;
      repeat (1 + $unsigned($random(seed)) % (DEB - 1)) @(posedge mclk);
      gpi_closed[k / 2] <= ~lv;
      repeat (200) @(posedge mclk);
      gpi_closed[k / 2] <= lv;
      exp_rec.push_back(3'(k + 1));
      drain(8000);
    end
    // recall refused by the module: status query follows, shown with link error
    s = 8'($random(seed)) | 8'h01;
    stat_val      <= s;
    nak_recall    <= 1'b1;
    gpi_closed[0] <= 1'b1;
    exp_rec.push_back(3'h1);
    push_msg(MSG_LINK_ERROR, 7'h05, s);
    drain(8000);
    nak_recall <= 1'b0;
    // fault status from every module; only the selected one is shown
    s = 8'($random(seed)) | 8'h02;
    poll_stat <= s;
    push_msg(MSG_STATUS, 7'h05, s);
    drain(8000);
    poll_stat <= 8'h00;
    // loss: time one sweep, then pull module 42 right after its answered poll
    wait_poll(7'h2a);
    t0 = cyc;
    wait_poll(7'h2a);
    per = cyc - t0;
    t0 = cyc;
    present[42] <= 1'b0;
    push_msg(MSG_GONE, 7'h2a, 8'h00);
    drain(40000);
    // ten missed sweeps, within half a sweep either way
    lv = (cyc - t0) * 2 > 19 * per && (cyc - t0) * 2 < 21 * per;
    check("loss delay", 32'h1, 32'(lv));
    conclude();
  end
endmodule // test_pp_poller
